// *** hdl/pfs_flow.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pfs_defines.svh"

// Functional notes
// RULE_01: Return stack holds only PC values, hidden from software with its index.
// RULE_02: Call or interrupt acknowledge pushes PC; depth is 4 or 6.
// RULE_03: Subroutine or interrupt return pops the stack into the PC.
// RULE_04: Any reset sets the stack index to the top level.
// RULE_05: Full stack latches the interrupt flag but withholds acknowledge.
// RULE_06: A held-off request is served once a return frees a level.
// RULE_07: A call on a full stack still executes and overflows.
// RULE_08: ALU writes result to named destination and updates carry and zero.
// RULE_09: Program memory is addressed by the PC; 1K, 2K or 4K words.
// RULE_10: Reset loads the PC with the reset vector.
// RULE_11: Selected edge on external pin vectors if enabled and stack not full.
// RULE_12: Timer overflow vectors to its own location when enabled, not full.
// RULE_13: Time base overflow vectors to its location when enabled, not full.
// RULE_14: Table pointer gives the low eight bits of every table address.
// RULE_15: Current-page read takes upper bits from PC; last-page forces ones.
// RULE_16: Table read writes low byte to memory, high part to table high.
// RULE_17: Table high byte is read-only to software.
// RULE_18: Every table read takes two instruction cycles.
// RULE_19: Table address is 10, 11 or 12 bits, matching memory size.
// RULE_20: Software should disable interrupts around main-routine table reads.
// RULE_21: Jumps, calls and returns take two instruction cycles.
// RULE_22: Simultaneous requests are acknowledged one at a time by priority.
module pfs_flow #(
   parameter int PC_W = 12,
   parameter int WORD_W = 15,
   parameter int STACK_DEPTH = 6
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Instruction decoder.
   input wire logic op_valid_i,
   input wire pfs_pkg::pfs_op_e op_i,
   input wire logic [PC_W-1:0] target_i,
   input wire logic [7:0] mem_addr_i,
   output logic ready_o,
   output logic [PC_W-1:0] pc_o,
   // ALU operands and results.
   input wire pfs_pkg::pfs_alu_e alu_op_i,
   input wire logic [7:0] alu_a_i,
   input wire logic [7:0] alu_b_i,
   input wire logic carry_i,
   input wire logic dest_mem_i,
   output logic alu_we_o,
   output logic alu_dest_mem_o,
   output logic [7:0] alu_result_o,
   output logic carry_o,
   output logic zero_o,
   // Interrupt sources and control.
   input wire logic ext_pin_i,
   input wire logic [1:0] edge_select_control_i,
   input wire logic tmr0_ovf_i,
   input wire logic tmr1_ovf_i,
   input wire logic tb_ovf_i,
   input wire logic global_int_en_i,
   input wire logic [`PFS_IRQ_N-1:0] int_en_i,
   output logic [`PFS_IRQ_N-1:0] int_flag_o,
   output logic irq_ack_o,
   output logic [`PFS_IRQ_N-1:0] irq_src_o,
   // Program memory, combinational read.
   output logic [PC_W-1:0] pmem_addr_o,
   input wire logic [WORD_W-1:0] pmem_data_i,
   // Table read results.
   input wire logic [7:0] table_pointer_low_i,
   output logic dm_we_o,
   output logic [7:0] dm_addr_o,
   output logic [7:0] dm_wdata_o,
   output logic [7:0] table_high_byte_o
);
   import pfs_pkg::*;
   localparam int PTR_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
   localparam int CNT_W = $clog2(STACK_DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(STACK_DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(STACK_DEPTH - 1);
   localparam logic [7:0] HI_MASK = 8'((1 << (WORD_W - 8)) - 1);
   localparam logic [PC_W-1:0] UPPER_ONES = ~PC_W'(8'hFF);
   pfs_state_e state_r, state_nxt;
   logic [PC_W-1:0] pc_r, pc_nxt, pmem_addr_r, pmem_addr_nxt;
   logic ready_r, ready_nxt;
   logic [PTR_W-1:0] ptr_r, ptr_nxt, top_ptr;
   logic [CNT_W-1:0] stack_level_index_r, stack_level_index_nxt;
   logic [PC_W-1:0] stack_r [STACK_DEPTH];
   logic [PC_W-1:0] stack_nxt [STACK_DEPTH];
   logic [`PFS_IRQ_N-1:0] pend_r, pend_nxt, req, grant, events, clr;
   logic pin_prev_r, ext_edge, full, take, irq_take;
   logic irq_ack_r, irq_ack_nxt, dm_we_r, dm_we_nxt;
   logic [`PFS_IRQ_N-1:0] irq_src_r, irq_src_nxt;
   logic [7:0] dm_addr_r, dm_addr_nxt, dm_wdata_r, dm_wdata_nxt;
   logic [7:0] table_high_byte_r, table_high_byte_nxt, alu_res_r, alu_res_nxt;
   logic alu_we_r, alu_we_nxt, alu_dest_r, alu_dest_nxt;
   logic carry_r, carry_nxt, zero_r, zero_nxt;
   logic [8:0] alu_sum;
   logic [PC_W-1:0] vector;
   assign full = (stack_level_index_r == FULL_CNT);
   assign take = ready_r && op_valid_i;
   assign top_ptr = (ptr_r == '0) ? LAST_PTR : ptr_r - PTR_W'(1);
   assign req = pend_r & int_en_i & {`PFS_IRQ_N{global_int_en_i}};
   // Lowest index wins: external, timer 0, timer 1, time base.
   // RULE_22 fixed priority grant
   assign grant = req & (~req + `PFS_IRQ_N'(1));
   // RULE_05 acknowledge held while full
   assign irq_take = (state_r == PFS_ST_RUN) && !ready_r && (|req) && !full;
   // RULE_11 edge selection
   assign ext_edge =
      (edge_select_control_i[`PFS_EDGE_RISE] && !pin_prev_r && ext_pin_i) ||
      (edge_select_control_i[`PFS_EDGE_FALL] && pin_prev_r && !ext_pin_i);
   assign events = {tb_ovf_i, tmr1_ovf_i, tmr0_ovf_i, ext_edge};
   // RULE_12 timer vectors
   assign vector = grant[`PFS_IRQ_EXT] ? PC_W'(`PFS_VEC_EXT) :
      grant[`PFS_IRQ_TMR0] ? PC_W'(`PFS_VEC_TMR0) :
      grant[`PFS_IRQ_TMR1] ? PC_W'(`PFS_VEC_TMR1) : PC_W'(`PFS_VEC_TB);
   always_comb begin
      alu_sum = 9'h000;
      alu_res_nxt = alu_res_r;
      carry_nxt = carry_r;
      zero_nxt = zero_r;
      // RULE_08 result and flags
      unique case (alu_op_i)
         PFS_ALU_ADD: alu_sum = {1'b0, alu_a_i} + {1'b0, alu_b_i};
         PFS_ALU_ADC: alu_sum = {1'b0, alu_a_i} + {1'b0, alu_b_i}
                                + {8'h00, carry_i};
         PFS_ALU_SUB: alu_sum = {1'b0, alu_a_i} + {1'b0, ~alu_b_i} + 9'h001;
         PFS_ALU_SBC: alu_sum = {1'b0, alu_a_i} + {1'b0, ~alu_b_i}
                                + {8'h00, carry_i};
         PFS_ALU_AND: alu_sum = {carry_i, alu_a_i & alu_b_i};
         PFS_ALU_OR: alu_sum = {carry_i, alu_a_i | alu_b_i};
         PFS_ALU_XOR: alu_sum = {carry_i, alu_a_i ^ alu_b_i};
         PFS_ALU_CPL: alu_sum = {carry_i, ~alu_a_i};
      endcase
      if (take && op_i == PFS_OP_ALU) begin
         alu_res_nxt = alu_sum[7:0];
         carry_nxt = alu_sum[8];
         zero_nxt = (alu_sum[7:0] == 8'h00);
      end
   end
   always_comb begin
      state_nxt = state_r;
      pc_nxt = pc_r;
      ptr_nxt = ptr_r;
      stack_level_index_nxt = stack_level_index_r;
      stack_nxt = stack_r;
      clr = '0;
      irq_ack_nxt = 1'b0;
      irq_src_nxt = irq_src_r;
      dm_we_nxt = 1'b0;
      dm_addr_nxt = dm_addr_r;
      dm_wdata_nxt = dm_wdata_r;
      table_high_byte_nxt = table_high_byte_r;
      alu_we_nxt = 1'b0;
      alu_dest_nxt = alu_dest_r;
      pmem_addr_nxt = pmem_addr_r;
      unique case (state_r)
         PFS_ST_RUN: begin
            if (take) begin
               unique case (op_i)
                  PFS_OP_NEXT: pc_nxt = pc_r + PC_W'(1);
                  PFS_OP_ALU: begin
                     pc_nxt = pc_r + PC_W'(1);
                     alu_we_nxt = 1'b1;
                     alu_dest_nxt = dest_mem_i;
                  end
                  // RULE_21 two-cycle branches
                  PFS_OP_JUMP: begin
                     pc_nxt = target_i;
                     state_nxt = PFS_ST_BRANCH;
                  end
                  // RULE_07 call never blocked
                  PFS_OP_CALL: begin
                     stack_nxt[ptr_r] = pc_r;
                     ptr_nxt = (ptr_r == LAST_PTR) ? '0 : ptr_r + PTR_W'(1);
                     if (!full) begin
                        stack_level_index_nxt =
                           stack_level_index_r + CNT_W'(1);
                     end
                     pc_nxt = target_i;
                     state_nxt = PFS_ST_BRANCH;
                  end
                  // RULE_03 pop on return
                  PFS_OP_SUB_RET, PFS_OP_INT_RET: begin
                     pc_nxt = stack_r[top_ptr];
                     ptr_nxt = top_ptr;
                     if (stack_level_index_r != '0) begin
                        stack_level_index_nxt =
                           stack_level_index_r - CNT_W'(1);
                     end
                     state_nxt = PFS_ST_BRANCH;
                  end
                  // RULE_15 page selection
                  PFS_OP_TRD_CUR, PFS_OP_TRD_LAST: begin
                     // RULE_14 pointer low bits
                     // RULE_19 PC-wide table address
                     pmem_addr_nxt = (op_i == PFS_OP_TRD_LAST) ?
                        (UPPER_ONES | PC_W'(table_pointer_low_i)) :
                        (pc_r & UPPER_ONES) | PC_W'(table_pointer_low_i);
                     dm_addr_nxt = mem_addr_i;
                     pc_nxt = pc_r + PC_W'(1);
                     state_nxt = PFS_ST_TABLE;
                  end
               endcase
            end else if (irq_take) begin
               // RULE_02 push on acknowledge
               stack_nxt[ptr_r] = pc_r;
               ptr_nxt = (ptr_r == LAST_PTR) ? '0 : ptr_r + PTR_W'(1);
               stack_level_index_nxt = stack_level_index_r + CNT_W'(1);
               // RULE_13 vectoring on acknowledge
               pc_nxt = vector;
               clr = grant;
               irq_ack_nxt = 1'b1;
               irq_src_nxt = grant;
               state_nxt = PFS_ST_BRANCH;
            end
         end
         PFS_ST_BRANCH: state_nxt = PFS_ST_RUN;
         // RULE_18 second table cycle
         PFS_ST_TABLE: begin
            // RULE_16 low byte and high part
            dm_we_nxt = 1'b1;
            dm_wdata_nxt = pmem_data_i[7:0];
            table_high_byte_nxt = 8'(pmem_data_i >> 8) & HI_MASK;
            state_nxt = PFS_ST_RUN;
         end
         default: state_nxt = PFS_ST_RUN;
      endcase
      // RULE_09 fetch from the PC
      if (state_nxt != PFS_ST_TABLE) begin
         pmem_addr_nxt = pc_nxt;
      end
      // A new event wins over the clear from an acknowledge.
      pend_nxt = (pend_r & ~clr) | events;
      // RULE_06 serve once a level frees
      ready_nxt = (state_nxt == PFS_ST_RUN) &&
         !((|(pend_nxt & int_en_i & {`PFS_IRQ_N{global_int_en_i}})) &&
           (stack_level_index_nxt != FULL_CNT));
   end

   // RULE_01 stack storage is internal
   always_ff @(posedge clk_i) begin
      stack_r <= stack_nxt;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= PFS_ST_RUN;
         // RULE_10 reset vector
         pc_r <= PC_W'(`PFS_VEC_RESET);
         pmem_addr_r <= PC_W'(`PFS_VEC_RESET);
         ready_r <= 1'b0;
         ptr_r <= '0;
         // RULE_04 index to top
         stack_level_index_r <= CNT_W'(`PFS_RST_LEVEL);
         pend_r <= '0;
         pin_prev_r <= ext_pin_i;
         irq_ack_r <= 1'b0;
         irq_src_r <= '0;
         dm_we_r <= 1'b0;
         dm_addr_r <= `PFS_RST_BYTE;
         dm_wdata_r <= `PFS_RST_BYTE;
         table_high_byte_r <= `PFS_RST_BYTE;
         alu_we_r <= 1'b0;
         alu_dest_r <= 1'b0;
         alu_res_r <= `PFS_RST_BYTE;
         carry_r <= 1'b0;
         zero_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         pc_r <= pc_nxt;
         pmem_addr_r <= pmem_addr_nxt;
         ready_r <= ready_nxt;
         ptr_r <= ptr_nxt;
         stack_level_index_r <= stack_level_index_nxt;
         pend_r <= pend_nxt;
         pin_prev_r <= ext_pin_i;
         irq_ack_r <= irq_ack_nxt;
         irq_src_r <= irq_src_nxt;
         dm_we_r <= dm_we_nxt;
         dm_addr_r <= dm_addr_nxt;
         dm_wdata_r <= dm_wdata_nxt;
         // RULE_17 no software write path
         table_high_byte_r <= table_high_byte_nxt;
         alu_we_r <= alu_we_nxt;
         alu_dest_r <= alu_dest_nxt;
         alu_res_r <= alu_res_nxt;
         carry_r <= carry_nxt;
         zero_r <= zero_nxt;
      end
   end
   assign {ready_o, pc_o, pmem_addr_o} = {ready_r, pc_r, pmem_addr_r};
   assign {int_flag_o, irq_ack_o, irq_src_o} =
      {pend_r, irq_ack_r, irq_src_r};
   assign {dm_we_o, dm_addr_o, dm_wdata_o} = {dm_we_r, dm_addr_r, dm_wdata_r};
   assign table_high_byte_o = table_high_byte_r;
   assign {alu_we_o, alu_dest_mem_o, alu_result_o} =
      {alu_we_r, alu_dest_r, alu_res_r};
   assign {carry_o, zero_o} = {carry_r, zero_r};

   call_target_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
      take && op_i == PFS_OP_CALL |=> pc_r == $past(target_i) && !ready_r)
      else $error("call did not load target");
   return_pop_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
      take && op_i inside {PFS_OP_SUB_RET, PFS_OP_INT_RET}
      |=> pc_r == $past(stack_r[top_ptr]))
      else $error("return did not restore pc");
   reset_state_a: assert property (@(posedge clk_i) // RULE_04
      rst_i |=> pc_r == PC_W'(`PFS_VEC_RESET) && stack_level_index_r == '0)
      else $error("reset state wrong");
   full_block_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
      irq_ack_r |-> $past(stack_level_index_r) != FULL_CNT)
      else $error("acknowledge given on full stack");
   held_served_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
      full && (|req) && take && op_i == PFS_OP_SUB_RET
      |-> ##[2:3] (irq_ack_r || !(|req)))
      else $error("held request not served");
   last_page_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_15
      take && op_i == PFS_OP_TRD_LAST
      |=> pmem_addr_r == (UPPER_ONES | PC_W'($past(table_pointer_low_i))))
      else $error("last page address wrong");
   table_two_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_18
      take && op_i inside {PFS_OP_TRD_CUR, PFS_OP_TRD_LAST}
      |=> !ready_r && !dm_we_r ##1 dm_we_r)
      else $error("table read not two cycles");
   high_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_16
      dm_we_r |-> (table_high_byte_r & ~HI_MASK) == 8'h00)
      else $error("unused high bits not zero");
   prio_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_22
      irq_ack_r && !irq_src_r[`PFS_IRQ_EXT] |-> !$past(req[`PFS_IRQ_EXT]))
      else $error("priority violated");
   alu_add_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
      take && op_i == PFS_OP_ALU && alu_op_i == PFS_ALU_ADD |=> alu_we_r &&
      alu_res_r == 8'($past(alu_a_i) + $past(alu_b_i)))
      else $error("add result wrong");
endmodule

`default_nettype wire

// *** hdl/pfs_defines.svh ***
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH

// Fixed program memory entry points, 12 bits wide.
`define PFS_VEC_RESET 12'h000
`define PFS_VEC_EXT 12'h004
`define PFS_VEC_TMR0 12'h008
`define PFS_VEC_TMR1 12'h00C
`define PFS_VEC_TB 12'h010

// Positions of the interrupt sources in request, enable and grant vectors.
`define PFS_IRQ_EXT 0
`define PFS_IRQ_TMR0 1
`define PFS_IRQ_TMR1 2
`define PFS_IRQ_TB 3
`define PFS_IRQ_N 4

// Bits of the edge select control field.
`define PFS_EDGE_RISE 0
`define PFS_EDGE_FALL 1

// Reset values.
`define PFS_RST_LEVEL 4'h0
`define PFS_RST_BYTE 8'h00

`endif

// *** hdl/pfs_pkg.sv ***
package pfs_pkg;

   typedef enum logic [2:0] {
      PFS_OP_NEXT = 3'h0,
      PFS_OP_ALU = 3'h1,
      PFS_OP_JUMP = 3'h2,
      PFS_OP_CALL = 3'h3,
      PFS_OP_SUB_RET = 3'h4,
      PFS_OP_INT_RET = 3'h5,
      PFS_OP_TRD_CUR = 3'h6,
      PFS_OP_TRD_LAST = 3'h7
   } pfs_op_e;

   typedef enum logic [2:0] {
      PFS_ALU_ADD = 3'h0,
      PFS_ALU_ADC = 3'h1,
      PFS_ALU_SUB = 3'h2,
      PFS_ALU_SBC = 3'h3,
      PFS_ALU_AND = 3'h4,
      PFS_ALU_OR = 3'h5,
      PFS_ALU_XOR = 3'h6,
      PFS_ALU_CPL = 3'h7
   } pfs_alu_e;

   typedef enum logic [1:0] {
      PFS_ST_RUN = 2'h0,
      PFS_ST_BRANCH = 2'h1,
      PFS_ST_TABLE = 2'h2
   } pfs_state_e;

endpackage

// *** verif/pfs_pmem_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module pfs_pmem_model #(
   parameter int PC_W = 12,
   parameter int WORD_W = 15
) (
   // Address from the core and the word returned in the same cycle.
   input wire logic [PC_W-1:0] addr_i,
   output logic [WORD_W-1:0] data_o
);
   // Each word is its own address under a fixed tag, so any address slip
   // shows in the returned data.
   // addressed word read
   assign data_o = WORD_W'({3'h5, addr_i});
endmodule

`default_nettype wire

// *** verif/pfs_flow_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pfs_defines.svh"

module pfs_flow_test;
   import pfs_pkg::*;
   logic clk_i, rst_i, op_valid_i, ready_o, carry_i, dest_mem_i;
   pfs_op_e op_i;
   pfs_alu_e alu_op_i;
   logic [11:0] target_i, pc_o, pmem_addr_o;
   logic [7:0] mem_addr_i, alu_a_i, alu_b_i, alu_result_o;
   logic alu_we_o, alu_dest_mem_o, carry_o, zero_o;
   logic ext_pin_i, tmr0_ovf_i, tmr1_ovf_i, tb_ovf_i, global_int_en_i;
   logic [1:0] edge_select_control_i;
   logic [3:0] int_en_i, int_flag_o, irq_src_o;
   logic irq_ack_o, dm_we_o;
   logic [14:0] pmem_data_i;
   logic [7:0] table_pointer_low_i, dm_addr_o, dm_wdata_o;
   logic [7:0] table_high_byte_o;
   int num_errors = 0;
   int total_checks = 0;

   pfs_flow #(.PC_W(12), .WORD_W(15), .STACK_DEPTH(6)) u_pfs_flow (
      .clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_i(op_i),
      .target_i(target_i), .mem_addr_i(mem_addr_i), .ready_o(ready_o),
      .pc_o(pc_o), .alu_op_i(alu_op_i), .alu_a_i(alu_a_i),
      .alu_b_i(alu_b_i), .carry_i(carry_i), .dest_mem_i(dest_mem_i),
      .alu_we_o(alu_we_o), .alu_dest_mem_o(alu_dest_mem_o),
      .alu_result_o(alu_result_o), .carry_o(carry_o), .zero_o(zero_o),
      .ext_pin_i(ext_pin_i), .edge_select_control_i(edge_select_control_i),
      .tmr0_ovf_i(tmr0_ovf_i), .tmr1_ovf_i(tmr1_ovf_i),
      .tb_ovf_i(tb_ovf_i), .global_int_en_i(global_int_en_i),
      .int_en_i(int_en_i), .int_flag_o(int_flag_o), .irq_ack_o(irq_ack_o),
      .irq_src_o(irq_src_o), .pmem_addr_o(pmem_addr_o),
      .pmem_data_i(pmem_data_i), .table_pointer_low_i(table_pointer_low_i),
      .dm_we_o(dm_we_o), .dm_addr_o(dm_addr_o), .dm_wdata_o(dm_wdata_o),
      .table_high_byte_o(table_high_byte_o));

   pfs_pmem_model #(.PC_W(12), .WORD_W(15)) u_pfs_pmem_model (
      .addr_i(pmem_addr_o), .data_o(pmem_data_i));

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   task automatic close_out;
      if (num_errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      total_checks++;
      if (e !== g) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic tick;
      @(posedge clk_i);
      #1;
   endtask

   // Waits on ready_o, or on irq_ack_o when ack is set.
   task automatic wait_on(input logic ack);
      for (int i = 0; i < 20; i++) begin
         if ((ack ? irq_ack_o : ready_o) === 1'b1) begin
            return;
         end
         tick;
      end
      num_errors++;
      close_out;
   endtask

   task automatic issue(input pfs_op_e op, input logic [11:0] t);
      tick;
      wait_on(1'b0);
      op_valid_i = 1'b1;
      op_i = op;
      target_i = t;
      tick;
      op_valid_i = 1'b0;
   endtask

   // Bit 1 timer 0, bit 2 timer 1, bit 3 time base.
   task automatic pulse(input logic [3:0] m);
      {tb_ovf_i, tmr1_ovf_i, tmr0_ovf_i} = m[3:1];
      tick;
      {tb_ovf_i, tmr1_ovf_i, tmr0_ovf_i} = 3'h0;
   endtask

   task automatic do_reset;
      rst_i = 1'b1;
      repeat (5) tick;
      chk("pc_o", 16'(`PFS_VEC_RESET), 16'(pc_o));
      chk("pmem_addr_o", 16'h0000, 16'(pmem_addr_o));
      chk("ready_o", 16'h0000, 16'(ready_o));
      rst_i = 1'b0;
      tick;
      chk("ready_o", 16'h0001, 16'(ready_o));
   endtask

   task automatic svc(input int i, input logic [11:0] v,
                      input logic [11:0] r, input logic do_ret);
      wait_on(1'b1);
      // The routine runs masked, as the decoder clears the global enable.
      global_int_en_i = 1'b0;
      chk("irq_src_o", 16'(4'h1 << i), 16'(irq_src_o));
      chk("pc_o", 16'(v), 16'(pc_o));
      chk("int_flag_o", 16'h0000, 16'(int_flag_o[i]));
      issue(PFS_OP_INT_RET, 12'h000);
      if (do_ret) begin
         chk("pc_o", 16'(r), 16'(pc_o));
      end
   endtask

   task automatic no_ack(input int k);
      int n;
      n = 0;
      repeat (k) begin
         tick;
         if (irq_ack_o === 1'b1) begin
            n++;
         end
      end
      chk("ack count", 16'h0000, 16'(n));
   endtask

   task automatic alu_case(input pfs_alu_e f, input logic [7:0] a,
                           input logic [7:0] b, input logic c,
                           input logic [9:0] x);
      alu_op_i = f;
      alu_a_i = a;
      alu_b_i = b;
      carry_i = c;
      issue(PFS_OP_ALU, 12'h000);
      chk("alu_result_o", 16'(x[7:0]), 16'(alu_result_o));
      chk("carry_o", 16'(x[8]), 16'(carry_o));
      chk("zero_o", 16'(x[9]), 16'(zero_o));
   endtask

   task automatic t_call;
      logic [11:0] r;
      r = pc_o;
      issue(PFS_OP_CALL, 12'h123);
      chk("pc_o", 16'h0123, 16'(pc_o));
      chk("ready_o", 16'h0000, 16'(ready_o));
      tick;
      chk("ready_o", 16'h0001, 16'(ready_o));
      issue(PFS_OP_NEXT, 12'h000);
      chk("pc_o", 16'h0124, 16'(pc_o));
      issue(PFS_OP_SUB_RET, 12'h000);
      chk("pc_o", 16'(r), 16'(pc_o));
   endtask

   task automatic t_alu;
      alu_op_i = PFS_ALU_ADD;
      alu_a_i = 8'hF0;
      alu_b_i = 8'h20;
      dest_mem_i = 1'b1;
      issue(PFS_OP_ALU, 12'h000);
      chk("alu_we_o", 16'h0001, 16'(alu_we_o));
      chk("alu_result_o", 16'h0010, 16'(alu_result_o));
      chk("carry_o", 16'h0001, 16'(carry_o));
      chk("alu_dest_mem_o", 16'h0001, 16'(alu_dest_mem_o));
      alu_op_i = PFS_ALU_SUB;
      alu_a_i = 8'h5A;
      alu_b_i = 8'h5A;
      dest_mem_i = 1'b0;
      issue(PFS_OP_ALU, 12'h000);
      chk("zero_o", 16'h0001, 16'(zero_o));
      chk("carry_o", 16'h0001, 16'(carry_o));
      chk("alu_dest_mem_o", 16'h0000, 16'(alu_dest_mem_o));
      alu_case(PFS_ALU_ADC, 8'h7F, 8'h00, 1'b1, 10'h080);
      alu_case(PFS_ALU_SBC, 8'h10, 8'h20, 1'b1, 10'h0F0);
      alu_case(PFS_ALU_AND, 8'hF0, 8'h0F, 1'b1, 10'h300);
      alu_case(PFS_ALU_OR, 8'hA0, 8'h05, 1'b0, 10'h0A5);
      alu_case(PFS_ALU_XOR, 8'hFF, 8'h0F, 1'b1, 10'h1F0);
      alu_case(PFS_ALU_CPL, 8'h5A, 8'h00, 1'b0, 10'h0A5);
   endtask

   task automatic t_table;
      // Interrupts stay off around main-line table reads.
      global_int_en_i = 1'b0;
      table_pointer_low_i = 8'h06;
      mem_addr_i = 8'h33;
      issue(PFS_OP_TRD_LAST, 12'h000);
      chk("pmem_addr_o", 16'h0F06, 16'(pmem_addr_o));
      chk("ready_o", 16'h0000, 16'(ready_o));
      tick;
      chk("dm_we_o", 16'h0001, 16'(dm_we_o));
      chk("dm_addr_o", 16'h0033, 16'(dm_addr_o));
      chk("dm_wdata_o", 16'h0006, 16'(dm_wdata_o));
      chk("table_high_byte_o", 16'h005F, 16'(table_high_byte_o));
      issue(PFS_OP_JUMP, 12'hA80);
      chk("pc_o", 16'h0A80, 16'(pc_o));
      table_pointer_low_i = 8'hC3;
      issue(PFS_OP_TRD_CUR, 12'h000);
      chk("pmem_addr_o", 16'h0AC3, 16'(pmem_addr_o));
      tick;
      chk("dm_wdata_o", 16'h00C3, 16'(dm_wdata_o));
      chk("table_high_byte_o", 16'h005A, 16'(table_high_byte_o));
   endtask

   task automatic t_ext;
      logic [11:0] r;
      for (int m = 0; m < 4; m++) begin
         global_int_en_i = 1'b0;
         edge_select_control_i = 2'(m);
         ext_pin_i = 1'b1;
         repeat (4) tick;
         chk("flag rise", 16'(m & 1), 16'(int_flag_o[0]));
         ext_pin_i = 1'b0;
         repeat (4) tick;
         chk("flag fall", 16'(m != 0), 16'(int_flag_o[0]));
         if (m != 0) begin
            r = pc_o;
            global_int_en_i = 1'b1;
            svc(0, `PFS_VEC_EXT, r, 1'b1);
         end
      end
   endtask

   task automatic t_irq;
      logic [11:0] r;
      logic [11:0] vec [4];
      vec = '{`PFS_VEC_EXT, `PFS_VEC_TMR0, `PFS_VEC_TMR1, `PFS_VEC_TB};
      for (int i = 1; i < 4; i++) begin
         global_int_en_i = 1'b1;
         r = pc_o;
         pulse(4'h1 << i);
         svc(i, vec[i], r, 1'b1);
      end
      global_int_en_i = 1'b0;
      pulse(4'hC);
      tick;
      r = pc_o;
      global_int_en_i = 1'b1;
      svc(2, vec[2], r, 1'b1);
      global_int_en_i = 1'b1;
      svc(3, vec[3], r, 1'b1);
      // A disabled source keeps its flag but is not acknowledged.
      int_en_i = 4'hD;
      global_int_en_i = 1'b1;
      r = pc_o;
      pulse(4'h2);
      no_ack(4);
      chk("int_flag_o", 16'h0001, 16'(int_flag_o[1]));
      int_en_i = 4'hF;
      svc(1, vec[1], r, 1'b1);
   endtask

   task automatic t_full;
      logic [11:0] r;
      global_int_en_i = 1'b1;
      for (int i = 0; i < 6; i++) begin
         issue(PFS_OP_CALL, 12'(12'h200 + i * 16));
      end
      pulse(4'h2);
      no_ack(6);
      chk("int_flag_o", 16'h0001, 16'(int_flag_o[1]));
      issue(PFS_OP_CALL, 12'h345);
      chk("pc_o", 16'h0345, 16'(pc_o));
      issue(PFS_OP_SUB_RET, 12'h000);
      svc(1, `PFS_VEC_TMR0, 12'h250, 1'b1);
      do_reset;
      r = pc_o;
      global_int_en_i = 1'b1;
      pulse(4'h2);
      svc(1, `PFS_VEC_TMR0, r, 1'b1);
   endtask

   initial begin
      rst_i = 1'b1;
      op_valid_i = 1'b0;
      op_i = PFS_OP_NEXT;
      target_i = 12'h000;
      mem_addr_i = 8'h00;
      alu_op_i = PFS_ALU_ADD;
      alu_a_i = 8'h00;
      alu_b_i = 8'h00;
      carry_i = 1'b0;
      dest_mem_i = 1'b0;
      ext_pin_i = 1'b0;
      edge_select_control_i = 2'h0;
      {tb_ovf_i, tmr1_ovf_i, tmr0_ovf_i} = 3'h0;
      global_int_en_i = 1'b0;
      int_en_i = 4'hF;
      table_pointer_low_i = 8'h00;
      do_reset;
      t_call;
      t_alu;
      t_table;
      t_ext;
      t_irq;
      t_full;
      close_out;
   end
endmodule

`default_nettype wire
